// ---- pixout_defines.vh ----
// constants for the pixel output control block
`ifndef PIXOUT_DEFINES_VH
`define PIXOUT_DEFINES_VH
`define PIX_W 24
`define BLUE_LSB 0
`define GREEN_LSB 8
`define RED_LSB 16
`define FIFO_DEPTH 16
`define FIFO_AW 4
// link considered idle after this many pixel clocks with no data enable change
`define IDLE_PIXCLKS 16
`define IDLE_W 5
`endif

// ---- pix_fifo.v ----
// synchronous fifo with valid/ready on both sides
`default_nettype none
module pix_fifo #(
    parameter WIDTH = 28,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire wr = in_valid_i && in_ready_o;
    wire rd = out_valid_o && out_ready_i;
    assign in_ready_o = (cnt_r != DEPTH[AW:0]);
    assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
    assign out_data_o = mem[rp_r];
    always @(posedge clk_i) begin
        if (wr) begin
            mem[wp_r] <= in_data_i;
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (wr) begin
                wp_r <= wp_r + 1'b1;
            end
            if (rd) begin
                rp_r <= rp_r + 1'b1;
            end
            if (wr && !rd) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (rd && !wr) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // pix_fifo
`default_nettype wire

// ---- pixel_out_ctrl.v ----
// pixel output control of a dvi receiver: channel mapping, link detect, pixel pairing
// What this block does
// R1 - channel 2: red when active, control bit blanked
// R2 - link flag high while data enable toggles
// R3 - stagger select low offsets even/odd outputs
// R4 - output clock period one or two pixel clocks
// R5 - odd bus held low in one-pixel mode
// R6 - channel 0 blue/syncs, channel 1 green/control
// R7 - odd bus delayed, same output period
`default_nettype none
`include "pixout_defines.vh"
module pixel_out_ctrl (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // recovered link (foreign timing)
    input wire pix_clk_i,
    input wire data_enable_in_i,
    input wire [7:0] ch0_i,
    input wire [7:0] ch1_i,
    input wire [7:0] ch2_i,
    input wire [1:0] ch0_ctl_i,
    input wire ch1_ctl_i,
    input wire ch2_ctl_i,
    // mode pins
    input wire pixels_per_clock_select_i,
    input wire stagger_select_n_i,
    // panel side
    output reg output_data_clock_o,
    output reg [`PIX_W-1:0] even_pixel_bus_o,
    output reg [`PIX_W-1:0] odd_pixel_bus_o,
    output reg de_o,
    output reg hsync_o,
    output reg vsync_o,
    output reg channel1_control_bit_o,
    output reg channel2_control_bit_o,
    output reg link_active_flag_o,
    output wire fifo_overflow_o
);
    // one fifo word: syncs, two control bits, data enable, colour
    localparam IN_W = 2 + 1 + 1 + 1 + `PIX_W;
    localparam ST_EVEN = 1'b0;
    localparam ST_ODD = 1'b1;

    // two-stage synchronisers: every link and mode pin, the pixel clock too, passes two flops; rst_i does not
    reg [IN_W+2:0] s1_r;
    reg [IN_W+2:0] s2_r;
    wire [IN_W+2:0] raw = {pix_clk_i, pixels_per_clock_select_i, stagger_select_n_i,
        ch0_ctl_i, ch1_ctl_i, ch2_ctl_i, data_enable_in_i, ch2_i, ch1_i, ch0_i};
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= {(IN_W+3){1'b0}};
            s2_r <= {(IN_W+3){1'b0}};
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end
    wire pclk_s = s2_r[IN_W+2];
    wire two_pix = s2_r[IN_W+1];
    wire stagger_select_n_n = s2_r[IN_W];
    wire [`PIX_W-1:0] chan_s = s2_r[`PIX_W-1:0];
    wire de_s = s2_r[`PIX_W];
    wire c2_s = s2_r[`PIX_W+1];
    wire c1_s = s2_r[`PIX_W+2];
    wire [1:0] c0_s = s2_r[`PIX_W+4:`PIX_W+3];
    reg pclk_d_r;
    reg de_d_r;
    wire pclk_rise = pclk_s && !pclk_d_r;

    // capture one pixel per pixel-clock rising edge into the fifo
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [IN_W-1:0] fifo_out;
    reg fifo_pop;
    assign fifo_overflow_o = pclk_rise && !fifo_in_ready;
    pix_fifo #(.WIDTH(IN_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(pclk_rise),
        .in_ready_o(fifo_in_ready),
        .in_data_i({c0_s, c1_s, c2_s, de_s, chan_s}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out)
    );
    wire [`PIX_W-1:0] f_pix = fifo_out[`PIX_W-1:0];
    wire f_de = fifo_out[`PIX_W];
    wire f_c2 = fifo_out[`PIX_W+1];
    wire f_c1 = fifo_out[`PIX_W+2];
    wire [1:0] f_c0 = fifo_out[`PIX_W+4:`PIX_W+3];

    // link activity: idle counter of pixel clocks since data enable last changed
    // short threshold: a data enable level held longer than it reads as idle
    reg [`IDLE_W-1:0] idle_r;
    reg [`IDLE_W-1:0] idle_nxt;
    always @* begin
        idle_nxt = idle_r;
        if (pclk_rise) begin
            if (de_s != de_d_r) begin
                idle_nxt = {`IDLE_W{1'b0}}; // [R2]
            end else if (idle_r != `IDLE_W'h10) begin
                idle_nxt = idle_r + 1'b1;
            end
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            pclk_d_r <= 1'b0;
            de_d_r <= 1'b0;
            idle_r <= `IDLE_W'h10;
            link_active_flag_o <= 1'b0;
        end else begin
            pclk_d_r <= pclk_s;
            if (pclk_rise) begin
                de_d_r <= de_s;
            end
            idle_r <= idle_nxt;
            link_active_flag_o <= (idle_r < `IDLE_PIXCLKS); // [R2]
        end
    end

    // zero the colour of a blanked pixel
    function [`PIX_W-1:0] shown;
        input de;
        input [`PIX_W-1:0] pix;
        begin
            shown = de ? pix : {`PIX_W{1'b0}}; // [R1]
        end
    endfunction

    // output pairing state machine
    reg state_r;
    reg state_nxt;
    reg word_out;
    reg [`PIX_W-1:0] even_hold_r;
    reg [`PIX_W-1:0] odd_late_r;
    reg odd_pending_r;
    always @* begin
        fifo_pop = fifo_out_valid;
        state_nxt = state_r;
        word_out = 1'b0;
        if (!two_pix) begin
            state_nxt = ST_EVEN;
            word_out = fifo_pop; // [R4]
        end else if (fifo_pop) begin
            case (state_r)
                ST_EVEN: begin
                    state_nxt = ST_ODD;
                end
                ST_ODD: begin
                    state_nxt = ST_EVEN;
                    word_out = 1'b1; // [R4]
                end
                default: begin
                    state_nxt = ST_EVEN;
                end
            endcase
        end
    end

    // even half of a pair waits here; a staggered odd half lands one clock late
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_EVEN;
            even_hold_r <= {`PIX_W{1'b0}};
            odd_late_r <= {`PIX_W{1'b0}};
            odd_pending_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            odd_pending_r <= 1'b0;
            if (fifo_pop && two_pix && state_r == ST_EVEN) begin
                even_hold_r <= shown(f_de, f_pix);
            end
            if (word_out && two_pix && !stagger_select_n_n) begin
                odd_late_r <= shown(f_de, f_pix); // [R3]
                odd_pending_r <= 1'b1; // [R7]
            end
        end
    end

    // pixel buses change when a whole output word is ready, the staggered odd bus one clock after
    always @(posedge clk_i) begin
        if (rst_i) begin
            output_data_clock_o <= 1'b0;
            even_pixel_bus_o <= {`PIX_W{1'b0}};
            odd_pixel_bus_o <= {`PIX_W{1'b0}};
        end else begin
            output_data_clock_o <= word_out; // [R4]
            if (word_out) begin
                if (!two_pix) begin
                    even_pixel_bus_o <= shown(f_de, f_pix); // [R1] [R6]
                end else begin
                    even_pixel_bus_o <= even_hold_r;
                    if (stagger_select_n_n) begin
                        odd_pixel_bus_o <= shown(f_de, f_pix); // [R3]
                    end
                end
            end
            if (!two_pix) begin
                odd_pixel_bus_o <= {`PIX_W{1'b0}}; // [R5]
            end else if (odd_pending_r) begin
                odd_pixel_bus_o <= odd_late_r; // [R7]
            end
        end
    end

    // control bits follow the link only in blanking, aligned with the output word
    always @(posedge clk_i) begin
        if (rst_i) begin
            de_o <= 1'b0;
            hsync_o <= 1'b0;
            vsync_o <= 1'b0;
            channel1_control_bit_o <= 1'b0;
            channel2_control_bit_o <= 1'b0;
        end else if (word_out) begin
            de_o <= f_de; // [R1] [R6]
            if (!f_de) begin
                hsync_o <= f_c0[0]; // [R6]
                vsync_o <= f_c0[1]; // [R6]
                channel1_control_bit_o <= f_c1; // [R6]
                channel2_control_bit_o <= f_c2; // [R1]
            end
        end
    end
endmodule // pixel_out_ctrl
`default_nettype wire

// ---- pix_out_props.sv ----
// assertions on the pixel output control ports
`default_nettype none
module pix_out_props (
    // clock, reset, modes
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pixels_per_clock_select_i,
    input wire logic stagger_select_n_i,
    // panel side
    input wire logic output_data_clock_o,
    input wire logic [23:0] even_pixel_bus_o,
    input wire logic [23:0] odd_pixel_bus_o,
    input wire logic de_o,
    input wire logic channel2_control_bit_o,
    input wire logic link_active_flag_o,
    input wire logic fifo_overflow_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic p = pixels_per_clock_select_i;
    wire logic k = output_data_clock_o;
    wire logic [23:0] q = odd_pixel_bus_o;
    a_one_period: assert property (!p [*8] ##0 k |=> !k [*7]) else $error("short word");
    a_two_period: assert property (p [*8] ##0 k |=> !k [*8]) else $error("short pair");
    a_odd_idle: assert property (!p [*8] |-> q == 24'h0) else $error("odd bus set");
    a_stagger_lag: assert property (p && !stagger_select_n_i && k |-> $stable(q))
        else $error("odd bus early");
    a_blank_zero: assert property (!de_o |-> even_pixel_bus_o == 24'h0)
        else $error("pixels in blanking");
    a_ctl_hold: assert property (de_o && $past(de_o) |-> $stable(channel2_control_bit_o))
        else $error("control moved");
    a_link_seen: assert property ($changed(de_o) |-> link_active_flag_o)
        else $error("flag low");
    a_no_drop: assert property (!fifo_overflow_o) else $error("pixel dropped");
endmodule // pix_out_props
bind pixel_out_ctrl pix_out_props u_pix_out_props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pixels_per_clock_select_i(pixels_per_clock_select_i),
    .stagger_select_n_i(stagger_select_n_i),
    .output_data_clock_o(output_data_clock_o),
    .even_pixel_bus_o(even_pixel_bus_o),
    .odd_pixel_bus_o(odd_pixel_bus_o),
    .de_o(de_o),
    .channel2_control_bit_o(channel2_control_bit_o),
    .link_active_flag_o(link_active_flag_o),
    .fifo_overflow_o(fifo_overflow_o)
);
`default_nettype wire

// ---- tx_model.sv ----
// transmitter model: pixel clock, data enable, channel data
`default_nettype none
module tx_model (
    // frame control
    input wire logic run_i,
    input wire logic tog_i,
    // link
    output logic clk_o,
    output logic den_o,
    output logic [7:0] b_o,
    output logic [7:0] g_o,
    output logic [7:0] r_o,
    output logic [1:0] sync_o,
    output logic c1_o,
    output logic c2_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pc = 1'b0;
    logic [7:0] n = 8'h0;
    // clock stands low between frames; data moves on its fall
    always begin
        #400;
        pc = run_i & ~pc;
        n = run_i ? n + {7'h0, ~pc} : 8'h0;
    end
    assign clk_o = pc;
    assign den_o = tog_i & ~n[2];
    assign b_o = n;
    assign g_o = ~n;
    assign r_o = n + 8'h11;
    assign sync_o = n[1:0];
    assign c1_o = n[4];
    assign c2_o = n[3];
endmodule // tx_model
`default_nettype wire

// ---- pixel_out_ctrl_tb.sv ----
// bench for the pixel output control block
`default_nettype none
module pixel_out_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, rst_i, pix_clk_i, data_enable_in_i, ch1_ctl_i, ch2_ctl_i, run, tog;
    logic pixels_per_clock_select_i, stagger_select_n_i, output_data_clock_o, de_o, hsync_o;
    logic vsync_o, channel1_control_bit_o, channel2_control_bit_o, link_active_flag_o;
    logic [7:0] ch0_i, ch1_i, ch2_i;
    logic [1:0] ch0_ctl_i;
    logic [23:0] even_pixel_bus_o, odd_pixel_bus_o;
    logic fifo_overflow_o;
    logic drop_seen = 1'b0;
    int checks = 0;
    int mismatches = 0;
    tx_model u_tx_model (.run_i(run), .tog_i(tog), .clk_o(pix_clk_i), .den_o(data_enable_in_i),
        .b_o(ch0_i), .g_o(ch1_i), .r_o(ch2_i), .sync_o(ch0_ctl_i), .c1_o(ch1_ctl_i),
        .c2_o(ch2_ctl_i));
    pixel_out_ctrl u_pixel_out_ctrl (.*);
    always @(posedge clk_i) if (fifo_overflow_o === 1'b1) drop_seen <= 1'b1;
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) mismatches++;
        if (got !== exp) $display("unexpected at %0t: %h vs %h", $time, got, exp);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic frame(input logic p, input logic s, input logic t, input int len);
        int g;
        logic [7:0] b;
        logic a;
        logic [3:0] ctl;
        {pixels_per_clock_select_i, stagger_select_n_i, tog} <= {p, s, t};
        repeat (10) @(posedge clk_i);
        run <= 1'b1;
        for (int w = 0; w < len; w++) begin
            b = p ? 8'(2 * w) : 8'(w);
            a = t & ~b[2];
            for (g = 0; g < 40 && output_data_clock_o !== 1'b1; g++) @(posedge clk_i) #1;
            if (g == 40) mismatches++;
            if (g == 40) end_of_test();
            chk(even_pixel_bus_o, a ? {b + 8'h11, ~b, b} : 24'h0);
            chk(de_o, a);
            ctl = {channel2_control_bit_o, channel1_control_bit_o, vsync_o, hsync_o};
            if (!a) chk(ctl, {b[3], b[4], b[1], b[0] | p});
            @(posedge clk_i) #1;
            b = b + 8'h1;
            chk(odd_pixel_bus_o, a && p ? {b + 8'h11, ~b, b} : 24'h0);
        end
        @(posedge clk_i);
        run <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk(drop_seen, 1'b0);
    endtask
    task automatic one_pixel;
        frame(1'b0, 1'b1, 1'b1, 16);
        chk(link_active_flag_o, 1'b1);
    endtask
    task automatic two_pixel;
        frame(1'b1, 1'b1, 1'b1, 8);
        frame(1'b1, 1'b0, 1'b1, 8);
    endtask
    task automatic link_drop;
        frame(1'b0, 1'b1, 1'b0, 24);
        chk(link_active_flag_o, 1'b0);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, pixels_per_clock_select_i, stagger_select_n_i, run, tog} = 5'b10100;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        one_pixel();
        two_pixel();
        link_drop();
        end_of_test();
    end
endmodule // pixel_out_ctrl_tb
`default_nettype wire
